// ---- design/pxg_defs.svh ----
/*
  Constants for the port crossbar and general-purpose I/O block: special
  function register addresses, reset values, field positions and pin numbers.
  Assumes it is included by bare name from the design files that need it.
*/
`ifndef PXG_DEFS_SVH
`define PXG_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses in the special function register space
// ----------------------------------------------------------------------------
`define PXG_ADDR_PORT 8'h80
`define PXG_ADDR_SKIP 8'hE1
`define PXG_ADDR_SELA 8'hE2
`define PXG_ADDR_SELB 8'hE3
`define PXG_BITADDR_PORT_BASE 5'h10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PXG_RST_PORT 8'hFF
`define PXG_RST_SKIP 8'h00
`define PXG_RST_SELA 8'h00
`define PXG_RST_SELB 8'h00
`define PXG_SELB_RD_MASK 8'hC7

// ----------------------------------------------------------------------------
// Field positions, function select A
// ----------------------------------------------------------------------------
`define PXG_SELA_CAPT_HI 7
`define PXG_SELA_CAPT_LO 6
`define PXG_SELA_CMPASYNC 5
`define PXG_SELA_CMPSYNC 4
`define PXG_SELA_SYSCLK 3
`define PXG_SELA_TWOWIRE 2
`define PXG_SELA_RX 1
`define PXG_SELA_TX 0

// ----------------------------------------------------------------------------
// Field positions, function select B
// ----------------------------------------------------------------------------
`define PXG_SELB_PUD 7
`define PXG_SELB_XBAR_EN 6
`define PXG_SELB_T1 2
`define PXG_SELB_T0 1
`define PXG_SELB_ECI 0

// ----------------------------------------------------------------------------
// Fixed serial pins and capture field codes
// ----------------------------------------------------------------------------
`define PXG_PIN_TX 3'h4
`define PXG_PIN_RX 3'h5
`define PXG_CAPT_NONE 2'h0
`define PXG_CAPT_ZERO 2'h1
`define PXG_CAPT_ONE 2'h2
`define PXG_CAPT_ALL 2'h3

`endif

// ---- design/pxg_pkg.sv ----
/*
  Types shared by the crossbar decoder and the port top level.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pxg_pkg;

  // Peripheral signals in crossbar priority order; serial pins are fixed.
  typedef enum logic [3:0] {
    PXG_RES_NONE   = 4'h0,
    PXG_RES_SDA    = 4'h1,
    PXG_RES_SCL    = 4'h2,
    PXG_RES_CMP    = 4'h3,
    PXG_RES_CMPA   = 4'h4,
    PXG_RES_SYSCLK = 4'h5,
    PXG_RES_COMPARE_OUTPUT_ZERO   = 4'h6,
    PXG_RES_COMPARE_OUTPUT_ONE   = 4'h7,
    PXG_RES_COMPARE_OUTPUT_TWO   = 4'h8,
    PXG_RES_ECI    = 4'h9,
    PXG_RES_T0     = 4'hA,
    PXG_RES_T1     = 4'hB,
    PXG_RES_TX     = 4'hC,
    PXG_RES_RX     = 4'hD
  } pxg_res_t;

  typedef pxg_res_t pxg_owner_t [8];

endpackage

// ---- design/pxg_route_if.sv ----
/*
  Carrier between the port top level and the crossbar decoder: resource
  enables and skip mask go in, one owner per pin comes back.
  Assumes both ends sit in one clock domain; the decode is combinational.
*/
`timescale 1ns/1ps
interface pxg_route_if;
  import pxg_pkg::*;
  logic [13:0] resEnable;
  logic [7:0] pinSkip;
  pxg_owner_t pinOwner;

  modport top (output resEnable, output pinSkip, input pinOwner);
  modport xbar (input resEnable, input pinSkip, output pinOwner);
endinterface

// ---- design/pxg_crossbar.sv ----
/*
  Priority crossbar decoder. Gives each enabled resource the lowest pin that
  is neither skipped nor already taken; serial pins are fixed.
  Assumes the enables already include the crossbar master enable.
*/
`timescale 1ns/1ps
`include "pxg_defs.svh"
module pxg_crossbar
  import pxg_pkg::*;
(
  // Routing carrier
  pxg_route_if.xbar route
);

  // Lowest free pin; bit 3 flags that one was found.
  function automatic logic [3:0] lowestFree(input logic [7:0] used);
    logic [3:0] res;
    res = 4'h0;
    for (int p = 7; p >= 0; p--) begin
      if (!used[p]) begin
        res = {1'b1, 3'(p)};
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Priority decode
  // ---------------------------------------------------------------------------
  // A resource with its enable clear claims nothing, so later ones move down.
  always_comb begin
    logic [7:0] used;
    logic [3:0] pick;
    used = route.pinSkip;
    pick = 4'h0;
    for (int p = 0; p < 8; p++) begin
      route.pinOwner[p] = PXG_RES_NONE;
    end
    if (route.resEnable[PXG_RES_TX]) begin
      route.pinOwner[`PXG_PIN_TX] = PXG_RES_TX;
      used[`PXG_PIN_TX] = 1'b1;
    end
    if (route.resEnable[PXG_RES_RX]) begin
      route.pinOwner[`PXG_PIN_RX] = PXG_RES_RX;
      used[`PXG_PIN_RX] = 1'b1;
    end
    for (int r = 1; r <= 11; r++) begin
      if (route.resEnable[r]) begin
        pick = lowestFree(used);
        if (pick[3]) begin
          route.pinOwner[pick[2:0]] = pxg_res_t'(4'(r));
          used[pick[2:0]] = 1'b1;
        end
      end
    end
  end

endmodule

// ---- design/pxg_port_top.sv ----
/*
  Byte-wide port with priority crossbar and general-purpose I/O: the pin
  skip mask, two function select registers, the port data latch, pin
  drivers, weak pull-up controls and routing of peripheral signals.
  Assumes the core drives the special function register strobes in step
  with clk, pins are sampled synchronously, and output mode and analog
  selection come from registers outside this block.
*/
`timescale 1ns/1ps
`include "pxg_defs.svh"
// Function
// - External counter clock input routed when enabled.
// - Free digital pins serve as software I/O.
// - Port register byte and bit addressable.
// - Writes held in output latch until rewritten.
// - Ordinary reads return pin levels.
// - Read-modify-write byte instructions read the latch.
// - Single-bit writes also read the latch.
// - Modified latch value written back to latch.
// - Lowest free unskipped pin, fixed priority.
// - Crossbar enable bit activates routing.
// - Disabled crossbar leaves all drivers off.
// - Pull-ups on open-drain pins not driving low.
module pxg_port_top
  import pxg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Byte access to the special function registers
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic sfrRmw,
  output logic [7:0] sfrRdData,
  // Bit access to the port register
  input wire logic [7:0] bitAddr,
  input wire logic bitWrEn,
  input wire logic bitWrValue,
  input wire logic bitRdEn,
  output logic bitRdData,
  // Pin configuration held outside this block
  input wire logic [7:0] pushPullMode,
  input wire logic [7:0] analogMode,
  // Port pins
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic [7:0] pullupEn,
  // Peripheral outputs toward pins
  input wire logic serialTxOut,
  input wire logic sdaDriveOut,
  input wire logic sclDriveOut,
  input wire logic comparatorOutput,
  input wire logic comparatorAsyncOutput,
  input wire logic systemClockOut,
  input wire logic compareOutputZero,
  input wire logic compareOutputOne,
  input wire logic compareOutputTwo,
  // Pin levels toward peripherals
  output logic serialRxIn,
  output logic sdaIn,
  output logic sclIn,
  output logic counterExternalClockInput,
  output logic timerZeroIn,
  output logic timerOneIn
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] portData_reg;
  logic [7:0] pinSkipMask_reg;
  logic [7:0] functionSelA_reg;
  logic [7:0] functionSelB_reg;
  logic [7:0] portData_next;
  logic crossbarOn;
  logic bitHit;
  logic [7:0] pinLevelOut;
  logic [7:0] pinOpenDrain;
  pxg_route_if route ();

  // True when a bit address falls on the port register.
  function automatic logic isPortBit(input logic [7:0] addr);
    return addr[7:3] == `PXG_BITADDR_PORT_BASE;
  endfunction

  assign bitHit = isPortBit(bitAddr);
  assign crossbarOn = functionSelB_reg[`PXG_SELB_XBAR_EN];

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // Unused bits of select B are not stored, so they always read zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSkipMask_reg <= `PXG_RST_SKIP;
      functionSelA_reg <= `PXG_RST_SELA;
      functionSelB_reg <= `PXG_RST_SELB;
    end else if (sfrWrEn) begin
      if (sfrAddr == `PXG_ADDR_SKIP) begin
        pinSkipMask_reg <= sfrWrData;
      end
      if (sfrAddr == `PXG_ADDR_SELA) begin
        functionSelA_reg <= sfrWrData;
      end
      if (sfrAddr == `PXG_ADDR_SELB) begin
        functionSelB_reg <= sfrWrData & `PXG_SELB_RD_MASK;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Port data latch
  // ---------------------------------------------------------------------------
  // A byte write of a read-modify-write instruction carries the core's result,
  // which was computed from the latch value returned below.
  always_comb begin
    portData_next = portData_reg;
    if (sfrWrEn && sfrAddr == `PXG_ADDR_PORT) begin
      portData_next = sfrWrData;
    end else if (bitWrEn && bitHit) begin
      // Only the addressed bit changes; the others keep the latch, not the pin.
      portData_next[bitAddr[2:0]] = bitWrValue;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      portData_reg <= `PXG_RST_PORT;
    end else begin
      portData_reg <= portData_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Byte read data
  // ---------------------------------------------------------------------------
  // Read data is registered and appears the cycle after the read strobe.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdData <= 8'h00;
    end else if (sfrRdEn) begin
      unique case (sfrAddr)
        `PXG_ADDR_PORT: sfrRdData <= sfrRmw ? portData_reg : pinIn;
        `PXG_ADDR_SKIP: sfrRdData <= pinSkipMask_reg;
        `PXG_ADDR_SELA: sfrRdData <= functionSelA_reg;
        `PXG_ADDR_SELB: sfrRdData <= functionSelB_reg;
        default: sfrRdData <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Bit read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitRdData <= 1'b0;
    end else if (bitRdEn) begin
      if (!bitHit) begin
        bitRdData <= 1'b0;
      end else if (sfrRmw) begin
        bitRdData <= portData_reg[bitAddr[2:0]];
      end else begin
        bitRdData <= pinIn[bitAddr[2:0]];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Resource enables toward the decoder
  // ---------------------------------------------------------------------------
  // Every enable is gated by the master enable so a disabled crossbar owns no pin.
  always_comb begin
    logic [1:0] capt;
    capt = functionSelA_reg[`PXG_SELA_CAPT_HI:`PXG_SELA_CAPT_LO];
    route.resEnable = 14'h0000;
    route.resEnable[PXG_RES_TX] = functionSelA_reg[`PXG_SELA_TX];
    route.resEnable[PXG_RES_RX] = functionSelA_reg[`PXG_SELA_RX];
    route.resEnable[PXG_RES_SDA] = functionSelA_reg[`PXG_SELA_TWOWIRE];
    route.resEnable[PXG_RES_SCL] = functionSelA_reg[`PXG_SELA_TWOWIRE];
    route.resEnable[PXG_RES_CMP] = functionSelA_reg[`PXG_SELA_CMPSYNC];
    route.resEnable[PXG_RES_CMPA] = functionSelA_reg[`PXG_SELA_CMPASYNC];
    route.resEnable[PXG_RES_SYSCLK] = functionSelA_reg[`PXG_SELA_SYSCLK];
    route.resEnable[PXG_RES_COMPARE_OUTPUT_ZERO] = capt != `PXG_CAPT_NONE;
    route.resEnable[PXG_RES_COMPARE_OUTPUT_ONE] = capt == `PXG_CAPT_ONE || capt == `PXG_CAPT_ALL;
    route.resEnable[PXG_RES_COMPARE_OUTPUT_TWO] = capt == `PXG_CAPT_ALL;
    route.resEnable[PXG_RES_ECI] = functionSelB_reg[`PXG_SELB_ECI];
    route.resEnable[PXG_RES_T0] = functionSelB_reg[`PXG_SELB_T0];
    route.resEnable[PXG_RES_T1] = functionSelB_reg[`PXG_SELB_T1];
    if (!crossbarOn) begin
      route.resEnable = 14'h0000;
    end
  end

  assign route.pinSkip = pinSkipMask_reg;

  pxg_crossbar u_crossbar (
    .route(route.xbar)
  );

  // ---------------------------------------------------------------------------
  // Pin drivers and pull-ups
  // ---------------------------------------------------------------------------
  // Pins with no output resource carry the latch, which is how free pins act
  // as general-purpose outputs. Two-wire pins are open-drain whatever the mode.
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pinOpenDrain[p] = !pushPullMode[p];
      unique case (route.pinOwner[p])
        PXG_RES_TX: pinLevelOut[p] = serialTxOut;
        PXG_RES_SDA: pinLevelOut[p] = sdaDriveOut;
        PXG_RES_SCL: pinLevelOut[p] = sclDriveOut;
        PXG_RES_CMP: pinLevelOut[p] = comparatorOutput;
        PXG_RES_CMPA: pinLevelOut[p] = comparatorAsyncOutput;
        PXG_RES_SYSCLK: pinLevelOut[p] = systemClockOut;
        PXG_RES_COMPARE_OUTPUT_ZERO: pinLevelOut[p] = compareOutputZero;
        PXG_RES_COMPARE_OUTPUT_ONE: pinLevelOut[p] = compareOutputOne;
        PXG_RES_COMPARE_OUTPUT_TWO: pinLevelOut[p] = compareOutputTwo;
        default: pinLevelOut[p] = portData_reg[p];
      endcase
      if (route.pinOwner[p] == PXG_RES_SDA || route.pinOwner[p] == PXG_RES_SCL) begin
        pinOpenDrain[p] = 1'b1;
      end
    end
  end

  // Open-drain pins drive only a low; analog pins never drive.
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pinOut[p] = pinLevelOut[p];
      pinOe[p] = crossbarOn && !analogMode[p] && (!pinOpenDrain[p] || !pinLevelOut[p]);
      pullupEn[p] = !functionSelB_reg[`PXG_SELB_PUD] && !analogMode[p] && pinOpenDrain[p]
                    && !pinOe[p];
    end
  end

  // ---------------------------------------------------------------------------
  // Pin levels toward peripherals
  // ---------------------------------------------------------------------------
  // An input with no pin idles high, the level an unconnected pull-up gives.
  always_comb begin
    serialRxIn = 1'b1;
    sdaIn = 1'b1;
    sclIn = 1'b1;
    counterExternalClockInput = 1'b1;
    timerZeroIn = 1'b1;
    timerOneIn = 1'b1;
    for (int p = 0; p < 8; p++) begin
      unique case (route.pinOwner[p])
        PXG_RES_RX: serialRxIn = pinIn[p];
        PXG_RES_SDA: sdaIn = pinIn[p];
        PXG_RES_SCL: sclIn = pinIn[p];
        PXG_RES_ECI: counterExternalClockInput = pinIn[p];
        PXG_RES_T0: timerZeroIn = pinIn[p];
        PXG_RES_T1: timerOneIn = pinIn[p];
        default: ;
      endcase
    end
  end

endmodule

// ---- dv/pxg_pin_model.sv ----
/*
  Far side of the port: the board wiring around the eight pins.
  Assumes the bench chooses which pins the board holds and at what level.
*/
`timescale 1ns/1ps
module pxg_pin_model (
  // Clock
  input wire logic clk,
  // Pin side of the block
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullupEn,
  // Board drive chosen by the bench
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  // Resolved levels
  output logic [7:0] pinIn
);
  logic [7:0] float_reg = 8'h5A;
  logic [7:0] lowV;
  logic [7:0] highV;

  // A pin nobody holds wanders each cycle, so a stale level never passes.
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  // Wired-and: any low driver wins, then drivers high or the pull-up.
  assign lowV = (pinOe & ~pinOut) | (extEn & ~extVal);
  assign highV = (pinOe & pinOut) | (extEn & extVal) | pullupEn;
  assign pinIn = ~lowV & (highV | float_reg);
endmodule

// ---- dv/pxg_port_top_sva.sv ----
/*
  Checker for the port crossbar top level, bound beside it.
  Assumes strobes and pins are sampled on the rising edge of clk.
*/
`timescale 1ns/1ps
`include "pxg_defs.svh"
module pxg_port_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register access
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic sfrRmw,
  input wire logic [7:0] sfrRdData,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrEn,
  input wire logic bitWrValue,
  input wire logic bitRdEn,
  input wire logic bitRdData,
  // Pins
  input wire logic [7:0] pushPullMode,
  input wire logic [7:0] analogMode,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullupEn,
  // Peripherals
  input wire logic serialTxOut,
  input wire logic compareOutputZero,
  input wire logic compareOutputOne,
  input wire logic compareOutputTwo,
  input wire logic serialRxIn,
  input wire logic counterExternalClockInput,
  input wire logic timerZeroIn
);
  // ---------------------------------------------------------------
  // Shadow registers rebuilt from the strobes alone
  // ---------------------------------------------------------------
  logic [7:0] latchM_reg, skipM_reg, selAM_reg, selBM_reg, rdExp;
  logic portBit, bitExp;
  logic [1:0] code;
  assign portBit = bitAddr[7:3] == `PXG_BITADDR_PORT_BASE;
  assign rdExp = sfrRmw ? latchM_reg : pinIn;
  assign bitExp = sfrRmw ? latchM_reg[bitAddr[2:0]] : pinIn[bitAddr[2:0]];
  assign code = selAM_reg[7:6];

  // Byte write wins over a bit write in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latchM_reg <= `PXG_RST_PORT;
    end else if (sfrWrEn && sfrAddr == `PXG_ADDR_PORT) begin
      latchM_reg <= sfrWrData;
    end else if (bitWrEn && portBit) begin
      latchM_reg[bitAddr[2:0]] <= bitWrValue;
    end
  end

  // Routing registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skipM_reg <= `PXG_RST_SKIP;
      selAM_reg <= `PXG_RST_SELA;
      selBM_reg <= `PXG_RST_SELB;
    end else if (sfrWrEn) begin
      case (sfrAddr)
        `PXG_ADDR_SKIP: skipM_reg <= sfrWrData;
        `PXG_ADDR_SELA: selAM_reg <= sfrWrData;
        `PXG_ADDR_SELB: selBM_reg <= sfrWrData;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_xbar_off_quiet: assert property (!selBM_reg[6] |-> pinOe == 8'h00 && pinOut == latchM_reg)
    else $error("Pins driven or latch lost while crossbar off");
  a_port_read: assert property (sfrRdEn && sfrAddr == `PXG_ADDR_PORT |=> sfrRdData == $past(rdExp))
    else $error("Port byte read returned wrong source");
  a_bit_read: assert property (bitRdEn && portBit |=> bitRdData == $past(bitExp))
    else $error("Port bit read returned wrong source");
  a_pullup_gate: assert property ((pullupEn & (pinOe | analogMode | {8{selBM_reg[7]}})) == 8'h00)
    else $error("Pull-up on where it must be off");
  a_pullup_idle: assert property (!selBM_reg[6] |-> pullupEn == (~pushPullMode & ~analogMode & {8{~selBM_reg[7]}}))
    else $error("Pull-up set wrong with crossbar off");
  a_tx_fixed: assert property (selBM_reg[6] && selAM_reg[0] && !analogMode[4] |-> pinOut[4] == serialTxOut)
    else $error("Serial transmit not on pin four");
  a_capture_route: assert property (selBM_reg[6] && skipM_reg == 8'h00 && selAM_reg[5:1] == 5'h00 &&
    selBM_reg[2:0] == 3'h0 |-> pinOut[0] == (code != 2'h0 ? compareOutputZero : latchM_reg[0]) &&
    pinOut[1] == (code[1] ? compareOutputOne : latchM_reg[1]) &&
    pinOut[2] == (code == 2'h3 ? compareOutputTwo : latchM_reg[2]))
    else $error("Capture outputs routed wrong");
  a_eci_route: assert property (selBM_reg[6] && selAM_reg == 8'h00 && selBM_reg[2:0] == 3'h1 &&
    skipM_reg[1:0] != 2'h3 |-> counterExternalClockInput == (skipM_reg[0] ? pinIn[1] : pinIn[0]))
    else $error("Counter clock input taken from wrong pin");
  a_unrouted_high: assert property (!selBM_reg[6] |-> serialRxIn && counterExternalClockInput && timerZeroIn)
    else $error("Unrouted input not high");

  c_rmw_read: cover property (sfrRdEn && sfrRmw && sfrAddr == `PXG_ADDR_PORT);
  c_tx_route: cover property (selBM_reg[6] && selAM_reg[0]);
  c_eci_route: cover property (selBM_reg[6] && selBM_reg[0]);
  c_twowire_route: cover property (selBM_reg[6] && selAM_reg[2]);
endmodule

// ---- dv/pxg_port_top_tb_top.sv ----
/*
  Self-checking bench for the port crossbar top level with a pin model.
  Assumes fixed read latency of one cycle and combinational pins.
*/
`timescale 1ns/1ps
`include "pxg_defs.svh"
module pxg_port_top_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00, pushPullMode = 8'hFF, analogMode = 8'h00;
  logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, sfrRmw = 1'b0, bitWrEn = 1'b0, bitWrValue = 1'b0, bitRdEn = 1'b0;
  logic serialTxOut = 1'b0, sdaDriveOut = 1'b1, sclDriveOut = 1'b1, comparatorOutput = 1'b0;
  logic comparatorAsyncOutput = 1'b0, systemClockOut = 1'b0, compareOutputZero = 1'b1;
  logic compareOutputOne = 1'b1, compareOutputTwo = 1'b1;
  logic [7:0] extEn = 8'hFF, extVal = 8'h3C, sfrRdData, pinIn, pinOut, pinOe, pullupEn;
  logic bitRdData, serialRxIn, sdaIn, sclIn, counterExternalClockInput, timerZeroIn, timerOneIn;
  int num_errors = 0;
  int check_count = 0;

  pxg_port_top dut_u (.*);
  pxg_pin_model pins_u (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn), .extEn(extEn),
    .extVal(extVal), .pinIn(pinIn));

  // Free-running clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] exp, input logic [7:0] act);
    check_count++;
    if (act !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(posedge clk) #1;
    sfrWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic rmw, input logic [7:0] exp);
    @(posedge clk) #1;
    sfrAddr = a;
    sfrRmw = rmw;
    sfrRdEn = 1'b1;
    @(posedge clk) #1;
    sfrRdEn = 1'b0;
    sfrRmw = 1'b0;
    chk8(exp, sfrRdData);
  endtask
  task automatic bit_op(input logic [2:0] n, input logic wrOp, input logic v, input logic rmw, input logic exp);
    @(posedge clk) #1;
    bitAddr = {`PXG_BITADDR_PORT_BASE, n};
    bitWrValue = v;
    bitWrEn = wrOp;
    bitRdEn = !wrOp;
    sfrRmw = rmw;
    @(posedge clk) #1;
    bitWrEn = 1'b0;
    bitRdEn = 1'b0;
    sfrRmw = 1'b0;
    if (!wrOp) chk8({7'h00, exp}, {7'h00, bitRdData});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(`PXG_ADDR_SELA, 1'b0, 8'h00);
    rd(`PXG_ADDR_SELB, 1'b0, 8'h00);
    rd(`PXG_ADDR_PORT, 1'b1, 8'hFF);
    wr(8'hE5, 8'hA5);
    rd(8'hE5, 1'b0, 8'h00);
    wr(`PXG_ADDR_SELB, 8'hFF);
    rd(`PXG_ADDR_SELB, 1'b0, `PXG_SELB_RD_MASK);
    wr(`PXG_ADDR_SELB, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_gpio;
    wr(`PXG_ADDR_PORT, 8'h96);
    chk8(8'h00, pinOe);
    rd(`PXG_ADDR_PORT, 1'b0, 8'h3C);
    rd(`PXG_ADDR_PORT, 1'b1, 8'h96);
    wr(`PXG_ADDR_SELB, 8'h40);
    chk8(8'hFF, pinOe);
    chk8(8'h96, pinOut);
    extEn = 8'h00;
    rd(`PXG_ADDR_PORT, 1'b0, 8'h96);
    rd(`PXG_ADDR_PORT, 1'b1, 8'h96);
    wr(`PXG_ADDR_PORT, 8'h69);
    chk8(8'h69, pinOut);
    $display("t_gpio done");
  endtask
  task automatic t_bits;
    bit_op(3'h3, 1'b1, 1'b0, 1'b0, 1'b0);
    chk8(8'h61, pinOut);
    bit_op(3'h2, 1'b1, 1'b1, 1'b0, 1'b0);
    pushPullMode = 8'h00;
    extEn = 8'h04;
    extVal = 8'h00;
    bit_op(3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    bit_op(3'h2, 1'b0, 1'b0, 1'b1, 1'b1);
    chk8(8'h9A, pinOe);
    chk8(8'h65, pullupEn);
    analogMode = 8'h01;
    #1 chk8(8'h64, pullupEn);
    wr(`PXG_ADDR_SELB, 8'hC0);
    chk8(8'h00, pullupEn);
    analogMode = 8'h00;
    $display("t_bits done");
  endtask
  task automatic t_capture;
    pushPullMode = 8'hFF;
    extEn = 8'h00;
    wr(`PXG_ADDR_SELB, 8'h40);
    wr(`PXG_ADDR_PORT, 8'hF0);
    for (int c = 0; c < 4; c++) begin
      wr(`PXG_ADDR_SELA, {c[1:0], 6'h01});
      chk8(8'hE0 | ((8'h01 << c) - 8'h01), pinOut);
    end
    wr(`PXG_ADDR_SKIP, 8'h11);
    chk8(8'hEE, pinOut);
    wr(`PXG_ADDR_SELB, 8'h00);
    chk8(8'h00, pinOe);
    chk8(8'hF0, pinOut);
    wr(`PXG_ADDR_SELA, 8'h00);
    wr(`PXG_ADDR_SKIP, 8'h00);
    $display("t_capture done");
  endtask
  // Two-wire, comparator, clock and timer one routing; the two-wire pins stay open-drain.
  task automatic t_priority;
    comparatorOutput = 1'b1;
    systemClockOut = 1'b1;
    extEn = 8'h02;
    wr(`PXG_ADDR_PORT, 8'h00);
    wr(`PXG_ADDR_SELA, 8'h3C);
    wr(`PXG_ADDR_SELB, 8'h44);
    chk8(8'h17, pinOut);
    chk8(8'hFC, pinOe);
    chk8(8'h04, {5'h00, sdaIn, sclIn, timerOneIn});
    sdaDriveOut = 1'b0;
    #1 chk8(8'h02, pullupEn);
    sdaDriveOut = 1'b1;
    wr(`PXG_ADDR_SELB, 8'h00);
    wr(`PXG_ADDR_SELA, 8'h00);
    $display("t_priority done");
  endtask
  task automatic t_inputs;
    pushPullMode = 8'h00;
    wr(`PXG_ADDR_PORT, 8'hFF);
    extEn = 8'hFF;
    extVal = 8'h02;
    wr(`PXG_ADDR_SELB, 8'h41);
    chk8(8'h02, {6'h00, serialRxIn, counterExternalClockInput});
    wr(`PXG_ADDR_SKIP, 8'h01);
    chk8(8'h01, {7'h00, counterExternalClockInput});
    wr(`PXG_ADDR_SKIP, 8'h00);
    wr(`PXG_ADDR_SELB, 8'h43);
    chk8(8'h01, {6'h00, counterExternalClockInput, timerZeroIn});
    wr(`PXG_ADDR_SELB, 8'h40);
    chk8(8'h01, {7'h00, counterExternalClockInput});
    wr(`PXG_ADDR_SELA, 8'h02);
    chk8(8'h00, {7'h00, serialRxIn});
    $display("t_inputs done");
  endtask

  // Verdict and end of run, reached from the main sequence or the watchdog.
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence: reset held for twelve cycles, then each scenario.
  initial begin
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    t_regs();
    t_gpio();
    t_bits();
    t_capture();
    t_priority();
    t_inputs();
    finish_test();
  end

  // Watchdog so a hang still ends in the verdict.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule

bind pxg_port_top pxg_port_top_sva chk_u (.*);
